// *** ilc_pkg.sv ***
// Package for the four-level interrupt controller: addresses, fields, types
package ilc_pkg;
    localparam int ILC_NSRC = 6;
    // Register addresses in the core's register space
    localparam logic [7:0] ILC_ADDR_ENABLE = 8'hA8;
    localparam logic [7:0] ILC_ADDR_PRIO_LOW = 8'hB8;
    localparam logic [7:0] ILC_ADDR_PRIO_HIGH = 8'hB7;
    localparam logic [7:0] ILC_ADDR_STATUS = 8'hF0;
    localparam logic [7:0] ILC_ADDR_MASK = 8'hF1;
    // Reset values
    localparam logic [7:0] ILC_RST_ENABLE = 8'h00;
    localparam logic [7:0] ILC_RST_PRIO = 8'h00;
    localparam logic [7:0] ILC_RST_MASK = 8'h00;
    // Field positions in the enable register
    localparam int ILC_BIT_GLOBAL = 7;
    localparam int ILC_BIT_RSVD = 6;
    localparam logic [7:0] ILC_ENABLE_WMASK = 8'hBF;
    localparam logic [5:0] ILC_PRIO_WMASK = 6'h3F;
    // Status event bits
    localparam int ILC_EV_GRANT = 0;
    localparam int ILC_EV_PREEMPT = 1;
    localparam int ILC_EV_RETURN = 2;
    // Vector addresses, source order 0..5
    localparam logic [7:0] ILC_VEC_BASE = 8'h03;
    localparam logic [7:0] ILC_VEC_STEP = 8'h08;
    // Source request flags as they arrive
    typedef struct packed {
        logic timer_two_external_flag;
        logic timer_two_overflow;
        logic tx_complete_flag;
        logic rx_complete_flag;
        logic timer_one_overflow;
        logic ext_one_request;
        logic timer_zero_overflow;
        logic ext_zero_request;
    } ilc_flags_s;
    // Hardware clear strobes back to the flag owners
    typedef struct packed {
        logic ext_zero_clr;
        logic timer_zero_clr;
        logic ext_one_clr;
        logic timer_one_clr;
    } ilc_clr_s;
    typedef enum logic [1:0] {ILC_IDLE, ILC_VECTORING} ilc_state_e;
endpackage : ilc_pkg

// *** ilc_ctrl.sv ***
// Four-level nested interrupt controller with six sources
//
// Behaviour
// R01 - Six sources, external 0, timer 0, external 1, timer 1, serial, timer 2, each at one of four levels.
// R02 - A source's level is its high-priority bit over its low-priority bit, 11 being the highest.
// R03 - The high-priority register sits at B7H beside the enable and low-priority registers.
// R04 - A pending enabled request is granted when no equal or higher level is in service.
// R05 - A request is held pending while an equal or higher level handler runs.
// R06 - A higher level request preempts, and nesting is tracked so the preempted handler resumes.
// R07 - Same-level simultaneous requests are granted in fixed order, external 0 first, timer 2 last.
// R08 - A grant supplies vector 03H, 0BH, 13H, 1BH, 23H or 2BH by source.
// R09 - Vectoring clears edge-mode external flags and timer 0 and 1 overflow flags only.
// R10 - Serial requests on either completion flag, timer 2 on either of its flags, software clears them.
// R11 - Each enable bit 0 to 5 gates its own source, 1 enabling.
// R12 - Enable bit 6 is reserved, unimplemented and reads zero.
// R13 - Enable bit 7 gates every grant globally.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
module ilc_ctrl
    import ilc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Source flags and trigger modes
    input wire ilc_flags_s flags,
    input wire logic ext_zero_edge_mode,
    input wire logic ext_one_edge_mode,
    // Core handshake
    input wire logic vector_ack,
    input wire logic return_pulse,
    output logic vector_req,
    output logic [7:0] vector_addr,
    output ilc_clr_s flag_clr,
    output logic [1:0] active_level,
    output logic level_valid,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Interrupt out
    output logic irq
);
    logic [7:0] source_enable_reg;
    logic [5:0] priority_low_reg;
    logic [5:0] priority_high_reg;
    logic [2:0] status;
    logic [2:0] mask;
    logic [3:0] in_service;
    ilc_state_e state;
    logic [5:0] req;
    logic [5:0] elig;
    logic [2:0] win_src;
    logic win_found;
    logic [1:0] win_lvl;
    logic [2:0] cur_src;
    logic [2:0] next_status;
    logic [3:0] next_in_service;
    logic [2:0] svc_top;
    logic [2:0] next_top;

    // Highest level set in an in-service vector
    function automatic logic [2:0] top_level(input logic [3:0] v);
        logic [2:0] r;
        r = 3'h4;
        for (int i = 0; i < 4; i++) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : top_level

    // R02 level of one source from its two priority bits
    function automatic logic [1:0] src_level(input logic [2:0] s, input logic [5:0] hi,
                                             input logic [5:0] lo);
        return {hi[s], lo[s]};
    endfunction : src_level

    // R01 six sources in polling order
    // R10 combined serial and timer 2 requests
    assign req = {flags.timer_two_external_flag | flags.timer_two_overflow,
                  flags.tx_complete_flag | flags.rx_complete_flag,
                  flags.timer_one_overflow, flags.ext_one_request,
                  flags.timer_zero_overflow, flags.ext_zero_request};

    // Highest level in service now and after this edge
    assign svc_top = top_level(in_service);
    assign next_top = top_level(next_in_service);

    // R11 per-source gating, R13 global gate, R04 R05 level above service
    generate
        for (genvar g = 0; g < ILC_NSRC; g++) begin : g_elig
            logic [2:0] top;
            assign top = top_level(in_service);
            assign elig[g] = req[g] & source_enable_reg[g] & source_enable_reg[ILC_BIT_GLOBAL]
                             & ((top == 3'h4) | ({1'b0, src_level(3'(g), priority_high_reg,
                                 priority_low_reg)} > top));
        end
    endgenerate

    // R07 highest level wins, lowest index breaks ties
    always_comb begin
        win_found = 1'b0;
        win_src = 3'h0;
        win_lvl = 2'h0;
        for (int lv = 0; lv < 4; lv++) begin
            for (int s = ILC_NSRC - 1; s >= 0; s--) begin
                if (elig[s] && src_level(3'(s), priority_high_reg, priority_low_reg) == 2'(lv)) begin
                    win_found = 1'b1;
                    win_src = 3'(s);
                    win_lvl = 2'(lv);
                end
            end
        end
    end

    // Grant state: offer vector, wait for core acknowledge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ILC_IDLE;
            vector_req <= 1'b0;
            vector_addr <= 8'h00;
            cur_src <= 3'h0;
        end else begin
            case (state)
                ILC_IDLE: begin
                    if (win_found) begin
                        state <= ILC_VECTORING;
                        vector_req <= 1'b1;
                        cur_src <= win_src;
                        // R08 vector from source index
                        vector_addr <= ILC_VEC_BASE + 8'({win_src, 3'h0});
                    end
                end
                default: begin
                    if (vector_ack) begin
                        state <= ILC_IDLE;
                        vector_req <= 1'b0;
                    end
                end
            endcase
        end
    end

    // R06 nesting stack as one bit per level
    always_comb begin
        logic [2:0] t;
        t = top_level(in_service);
        next_in_service = in_service;
        if (return_pulse && t != 3'h4) begin
            next_in_service[t[1:0]] = 1'b0;
        end
        if (state == ILC_VECTORING && vector_ack) begin
            next_in_service[src_level(cur_src, priority_high_reg, priority_low_reg)] = 1'b1;
        end
    end

    // In-service tracking
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_service <= 4'h0;
            active_level <= 2'h0;
            level_valid <= 1'b0;
        end else begin
            in_service <= next_in_service;
            active_level <= (next_top == 3'h4) ? 2'h0 : next_top[1:0];
            level_valid <= |next_in_service;
        end
    end

    // R09 hardware clear strobes on acknowledge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_clr <= '0;
        end else begin
            flag_clr <= '0;
            if (state == ILC_VECTORING && vector_ack) begin
                flag_clr.ext_zero_clr <= (cur_src == 3'h0) & ext_zero_edge_mode;
                flag_clr.timer_zero_clr <= cur_src == 3'h1;
                flag_clr.ext_one_clr <= (cur_src == 3'h2) & ext_one_edge_mode;
                flag_clr.timer_one_clr <= cur_src == 3'h3;
            end
        end
    end

    // R03 register writes; R12 bit 6 never stored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            source_enable_reg <= ILC_RST_ENABLE;
            priority_low_reg <= ILC_PRIO_WMASK & 6'(ILC_RST_PRIO);
            priority_high_reg <= ILC_PRIO_WMASK & 6'(ILC_RST_PRIO);
            mask <= 3'(ILC_RST_MASK);
        end else if (reg_wr) begin
            if (reg_addr == ILC_ADDR_ENABLE) begin
                source_enable_reg <= reg_wdata & ILC_ENABLE_WMASK;
            end else if (reg_addr == ILC_ADDR_PRIO_LOW) begin
                priority_low_reg <= reg_wdata[5:0];
            end else if (reg_addr == ILC_ADDR_PRIO_HIGH) begin
                priority_high_reg <= reg_wdata[5:0];
            end else if (reg_addr == ILC_ADDR_MASK) begin
                mask <= reg_wdata[2:0];
            end
        end
    end

    // Sticky events, set wins over read-clear
    always_comb begin
        next_status = status;
        if (reg_rd && reg_addr == ILC_ADDR_STATUS) begin
            next_status = 3'h0;
        end
        if (state == ILC_VECTORING && vector_ack) begin
            next_status[ILC_EV_GRANT] = 1'b1;
            if (|in_service) begin
                next_status[ILC_EV_PREEMPT] = 1'b1;
            end
        end
        if (return_pulse && |in_service) begin
            next_status[ILC_EV_RETURN] = 1'b1;
        end
    end

    // Status, interrupt line and read data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status <= 3'h0;
            irq <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            status <= next_status;
            irq <= |(next_status & mask);
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                if (reg_addr == ILC_ADDR_ENABLE) begin
                    reg_rdata <= source_enable_reg;
                end else if (reg_addr == ILC_ADDR_PRIO_LOW) begin
                    reg_rdata <= {2'h0, priority_low_reg};
                end else if (reg_addr == ILC_ADDR_PRIO_HIGH) begin
                    reg_rdata <= {2'h0, priority_high_reg};
                end else if (reg_addr == ILC_ADDR_STATUS) begin
                    reg_rdata <= {5'h00, status};
                end else if (reg_addr == ILC_ADDR_MASK) begin
                    reg_rdata <= {5'h00, mask};
                end
            end
        end
    end

    // Checks
    sequence s_ack;
        state == ILC_VECTORING && vector_ack;
    endsequence

    sequence s_offer;
        state == ILC_IDLE && win_found;
    endsequence

    sequence s_pop;
        return_pulse && svc_top != 3'h4;
    endsequence

    // R13 global gate
    a_global_gate: assert property (@(posedge clk) disable iff (!rst_n) // R13
        state == ILC_IDLE && !source_enable_reg[ILC_BIT_GLOBAL] |=> !vector_req)
        else $error("grant while global gate off");
    // R13 gate blocks winner
    a_gate_off: assert property (@(posedge clk) disable iff (!rst_n) // R13
        !source_enable_reg[ILC_BIT_GLOBAL] |-> !win_found)
        else $error("winner while global gate off");
    // R08 vector values
    a_vector_value: assert property (@(posedge clk) disable iff (!rst_n) // R08
        vector_req |-> vector_addr == ILC_VEC_BASE + ILC_VEC_STEP * {5'h00, cur_src})
        else $error("wrong vector address");
    // R09 timer 0 flag cleared
    a_timer_clear: assert property (@(posedge clk) disable iff (!rst_n) // R09
        s_ack ##0 (cur_src == 3'h1) |=> flag_clr.timer_zero_clr)
        else $error("timer 0 flag not cleared");
    a_level_clear: assert property (@(posedge clk) disable iff (!rst_n) // R09
        s_ack ##0 (cur_src == 3'h0 && !ext_zero_edge_mode) |=> !flag_clr.ext_zero_clr)
        else $error("level external flag cleared");
    // R09 edge external cleared
    a_ext_clear: assert property (@(posedge clk) disable iff (!rst_n) // R09
        s_ack ##0 (cur_src == 3'h0 && ext_zero_edge_mode) |=> flag_clr.ext_zero_clr)
        else $error("edge external flag not cleared");
    // R09 external one by mode
    a_ext_one_clear: assert property (@(posedge clk) disable iff (!rst_n) // R09
        s_ack ##0 (cur_src == 3'h2) |=> flag_clr.ext_one_clr == $past(ext_one_edge_mode))
        else $error("external 1 clear does not follow its mode");
    // R09 serial and timer 2 kept
    a_serial_keep: assert property (@(posedge clk) disable iff (!rst_n) // R09
        s_ack ##0 (cur_src > 3'h3) |=> flag_clr == '0)
        else $error("software cleared flag hit by hardware");
    // R09 one cycle strobes
    a_clear_pulse: assert property (@(posedge clk) disable iff (!rst_n) // R09
        (|flag_clr) |=> !(|flag_clr))
        else $error("clear strobe longer than one cycle");
    // R05 no grant at or below level in service
    a_hold_pending: assert property (@(posedge clk) disable iff (!rst_n) // R05
        state == ILC_IDLE && win_found && top_level(in_service) != 3'h4
        |-> {1'b0, win_lvl} > top_level(in_service))
        else $error("grant at or below service level");
    // R06 nesting marks new level
    a_nest_mark: assert property (@(posedge clk) disable iff (!rst_n) // R06
        s_ack ##0 (!return_pulse)
        |=> in_service[$past(src_level(cur_src, priority_high_reg, priority_low_reg))])
        else $error("nesting not recorded");
    // R06 return pops top level
    a_return_pop: assert property (@(posedge clk) disable iff (!rst_n) // R06
        s_pop ##0 (!vector_ack) |=> !in_service[$past(svc_top[1:0])])
        else $error("return did not pop the top level");
    // R06 return event recorded
    a_return_status: assert property (@(posedge clk) disable iff (!rst_n) // R06
        s_pop |=> status[ILC_EV_RETURN])
        else $error("return event not recorded");
    // R06 level outputs track service
    a_level_out: assert property (@(posedge clk) disable iff (!rst_n) // R06
        level_valid == (|in_service) && (!level_valid || active_level == svc_top[1:0]))
        else $error("level outputs disagree with service state");
    // R04 grant follows an eligible request
    a_grant_cause: assert property (@(posedge clk) disable iff (!rst_n) // R04
        state == ILC_IDLE && win_found |=> vector_req && cur_src == $past(win_src))
        else $error("eligible request not granted");
    // R04 offer stands until taken
    a_req_hold: assert property (@(posedge clk) disable iff (!rst_n) // R04
        vector_req && !vector_ack |=> vector_req && $stable(vector_addr))
        else $error("offer withdrawn before acknowledge");
    // R04 offer drops after taking
    a_req_drop: assert property (@(posedge clk) disable iff (!rst_n) // R04
        s_ack |=> !vector_req)
        else $error("offer still up after acknowledge");
    // R04 grant event recorded
    a_grant_status: assert property (@(posedge clk) disable iff (!rst_n) // R04
        s_ack |=> status[ILC_EV_GRANT])
        else $error("grant event not recorded");
    // R11 winner is enabled
    a_src_enabled: assert property (@(posedge clk) disable iff (!rst_n) // R11
        s_offer |-> source_enable_reg[win_src])
        else $error("disabled source offered");
    // R12 reserved bit reads zero
    a_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n) // R12
        !source_enable_reg[ILC_BIT_RSVD])
        else $error("reserved enable bit set");
    // R07 lower index wins a tie
    a_poll_order: assert property (@(posedge clk) disable iff (!rst_n) // R07
        state == ILC_IDLE && elig[0] && elig[1] && priority_high_reg[1:0] == {2{priority_high_reg[0]}}
        && priority_low_reg[1:0] == {2{priority_low_reg[0]}} |-> win_src != 3'h1)
        else $error("polling order broken");
endmodule : ilc_ctrl

// *** ilc_core_model.sv ***
// Core model: takes offered vectors after a chosen delay and returns on command
`timescale 1ns/1ns
module ilc_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Controller side
    input wire logic vector_req,
    input wire logic [7:0] vector_addr,
    output logic vector_ack,
    output logic return_pulse,
    // Bench control
    input wire logic [1:0] ack_delay,
    input wire logic ret_cmd,
    output logic taken,
    output logic [7:0] taken_addr
);
    logic [1:0] cnt;
    // Accept after ack_delay cycles, then rest a cycle so one offer is never taken twice
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vector_ack <= 1'b0;
            taken <= 1'b0;
            taken_addr <= 8'h00;
            cnt <= 2'h0;
        end else if (vector_ack) begin
            vector_ack <= 1'b0;
            taken <= 1'b1;
            taken_addr <= vector_addr;
            cnt <= 2'h0;
        end else if (taken) begin
            taken <= 1'b0;
        end else if (vector_req) begin
            vector_ack <= (cnt == ack_delay);
            cnt <= cnt + 2'h1;
        end else begin
            cnt <= 2'h0;
        end
    end
    // Handler completion strobe, one cycle
    always_ff @(posedge clk) begin
        return_pulse <= rst_n & ret_cmd;
    end
endmodule : ilc_core_model

// *** ilc_tb.sv ***
// Self-checking bench for the interrupt controller with a core model
`timescale 1ns/1ns
module testbench
    import ilc_pkg::*;
;
    logic clk, rst_n, ext_zero_edge_mode, ext_one_edge_mode, vector_ack, return_pulse;
    logic vector_req, level_valid, reg_wr, reg_rd, irq, ret_cmd, taken;
    ilc_flags_s flags;
    ilc_clr_s flag_clr;
    logic [1:0] active_level, ack_delay;
    logic [7:0] vector_addr, reg_addr, reg_wdata, reg_rdata, taken_addr, en, hi, lo, rd;
    logic [1:0] lvl [6];
    logic [5:0] pend;
    logic [7:0] ra [6] = '{8'hA8, 8'hB8, 8'hB7, 8'hF0, 8'hF1, 8'h55};
    int miscompares, samples_checked, k;
    ilc_ctrl dut_u (.clk(clk), .rst_n(rst_n), .flags(flags),
        .ext_zero_edge_mode(ext_zero_edge_mode), .ext_one_edge_mode(ext_one_edge_mode),
        .vector_ack(vector_ack), .return_pulse(return_pulse), .vector_req(vector_req),
        .vector_addr(vector_addr), .flag_clr(flag_clr), .active_level(active_level),
        .level_valid(level_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    ilc_core_model core_u (.clk(clk), .rst_n(rst_n), .vector_req(vector_req),
        .vector_addr(vector_addr), .vector_ack(vector_ack), .return_pulse(return_pulse),
        .ack_delay(ack_delay), .ret_cmd(ret_cmd), .taken(taken), .taken_addr(taken_addr));
    // Clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Flag owners drop a source's flags at the edge the core accepts its vector
    always @(posedge clk) begin
        if (vector_ack === 1'b1 && vector_req === 1'b1)
            flags <= flags & ~src_bits(vector_addr);
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done;
    end
    function automatic logic [7:0] src_bits(input logic [7:0] a);
        src_bits = (a[5:3] < 3'h4) ? (8'h01 << a[5:3]) : (a[3] ? 8'hC0 : 8'h30);
    endfunction : src_bits
    function automatic int pick(input logic [5:0] p);
        pick = -1;
        for (int l = 3; l >= 0; l--)
            for (int i = 0; i < 6; i++)
                if (pick < 0 && p[i] && lvl[i] == 2'(l)) pick = i;
    endfunction : pick
    function automatic logic [3:0] clr_of(input int i);
        clr_of = (i == 0) ? {ext_zero_edge_mode, 3'h0} : (i == 2) ? {2'h0, ext_one_edge_mode, 1'h0}
            : (i == 1) ? 4'h4 : (i == 3) ? 4'h1 : 4'h0;
    endfunction : clr_of
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rchk
    task automatic grant(input int i, input logic [1:0] l, input logic [3:0] c);
        int w;
        w = 0;
        do begin
            @(posedge clk);
            #1;
            w++;
        end while (taken !== 1'b1 && w < 60);
        chk({7'h0, taken}, 8'h01);
        chk(taken_addr, 8'h03 + 8'(i * 8));
        chk({5'h0, level_valid, active_level}, {5'h1, l});
        chk({4'h0, flag_clr}, {4'h0, c});
    endtask : grant
    task automatic ret;
        @(posedge clk);
        ret_cmd <= 1'b1;
        @(posedge clk);
        ret_cmd <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : ret
    task automatic test_done;
        if (miscompares == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    // Main sequence
    initial begin
        rst_n = 1'b0;
        flags = '0;
        {ext_zero_edge_mode, ext_one_edge_mode, reg_wr, reg_rd, ret_cmd} = '0;
        {reg_addr, reg_wdata, ack_delay, hi, lo} = '0;
        miscompares = 0;
        samples_checked = 0;
        void'($urandom(35025));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ra[i]) rchk(ra[i], 8'h00);
        wr(8'hA8, 8'hFF);
        rchk(8'hA8, 8'hBF);
        wr(8'hB7, 8'hFF);
        rchk(8'hB7, 8'h3F);
        wr(8'h55, 8'hFF);
        rchk(8'h55, 8'h00);
        repeat (8) begin
            foreach (lvl[i]) lvl[i] = 2'($urandom);
            foreach (lvl[i]) {hi[i], lo[i]} = lvl[i];
            en = {2'h0, 6'($urandom) | 6'h01};
            ack_delay <= 2'($urandom);
            ext_zero_edge_mode <= 1'($urandom);
            ext_one_edge_mode <= 1'($urandom);
            wr(8'hB7, hi);
            wr(8'hB8, lo);
            wr(8'hA8, en);
            flags <= 8'hFF;
            repeat (8) @(posedge clk);
            #1;
            chk({7'h0, vector_req}, 8'h00);
            wr(8'hA8, en | 8'h80);
            pend = en[5:0];
            while (pend != 6'h00) begin
                k = pick(pend);
                grant(k, lvl[k], clr_of(k));
                ret;
                pend[k] = 1'b0;
            end
            repeat (8) @(posedge clk);
            #1;
            chk({7'h0, vector_req}, 8'h00);
            flags <= '0;
        end
        rchk(8'hF0, 8'h05);
        wr(8'hB7, 8'h08);
        wr(8'hB8, 8'h0A);
        wr(8'hA8, 8'h8B);
        ack_delay <= 2'h3;
        flags.ext_zero_request <= 1'b1;
        grant(0, 2'h0, clr_of(0));
        flags.timer_one_overflow <= 1'b1;
        grant(3, 2'h3, clr_of(3));
        flags.timer_zero_overflow <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk({7'h0, vector_req}, 8'h00);
        ret;
        grant(1, 2'h1, clr_of(1));
        ret;
        chk({5'h0, level_valid, active_level}, 8'h04);
        ret;
        chk({6'h0, level_valid, irq}, 8'h00);
        wr(8'hF1, 8'h07);
        @(posedge clk);
        #1;
        chk({7'h0, irq}, 8'h01);
        rchk(8'hF0, 8'h07);
        @(posedge clk);
        #1;
        chk({7'h0, irq}, 8'h00);
        test_done;
    end
endmodule : testbench
